// File: rtl/position_error_guard.sv
// Decided for this implementation: the address map and the strobed register port.
`timescale 1ns/1ns
`default_nettype none
module position_error_guard
	import position_error_guard_pkg::*;
(
	input  wire logic               clock,        // 20 MHz control clock
	input  wire logic               srst,         // Synchronous reset, high
	input  wire logic               pos_control,  // Position control mode active
	input  wire logic               servo_on,     // Motor power request
	input  wire logic [POS_W-1:0]   ref_delta,    // Reference increment this cycle
	input  wire logic               ref_valid,    // Reference increment present
	input  wire logic [POS_W-1:0]   fb_delta,     // Feedback increment this cycle
	input  wire logic               alarm_clear,  // External alarm clear
	input  wire logic [3:0]         reg_addr,     // Register address
	input  wire logic [31:0]        reg_wdata,    // Register write data
	input  wire logic               reg_wr,       // Register write strobe
	input  wire logic               reg_rd,       // Register read strobe
	output logic      [31:0]        reg_rdata,    // Read data, cycle after strobe
	output logic                    motor_enable, // Motor power allowed
	output logic                    motor_stop,   // Stop command to drive
	output logic                    speed_clamp,  // Speed clamp active
	output logic      [SPEED_W-1:0] speed_limit,  // Active speed ceiling
	output logic                    error_overflow_alarm,       // Main overflow alarm
	output logic                    servo_on_overflow_alarm,    // Servo-on overflow alarm
	output logic                    speed_clamp_overflow_alarm, // Clamp overflow alarm
	output logic                    servo_on_warning,           // Servo-on warning flag
	output logic                    irq           // Unmasked status pending
);

	////////////////////////////////////////////////////////////////////
	// Settings and register file

	logic [LEVEL_W-1:0] overflow_alarm_level_q;
	logic [LEVEL_W-1:0] servo_on_alarm_level_q;
	logic [PCT_W-1:0]   servo_on_warning_percent_q;
	logic [SPEED_W-1:0] servo_on_speed_limit_q;
	logic [EV_W-1:0]    status_q;
	logic [EV_W-1:0]    mask_q;
	logic [ERR_W-1:0]   err_count_q;
	guard_state_t       state_q;

	function automatic logic [LEVEL_W-1:0] clip_level(input logic [31:0] v);
		if (v[31:LEVEL_W] != '0)
			return LEVEL_MAX;
		else if (v[LEVEL_W-1:0] < LEVEL_MIN)
			return LEVEL_MIN;
		else
			return v[LEVEL_W-1:0];
	endfunction : clip_level

	// One write decode shared by every register; strobe passed in so
	// the continuous assignments below follow it
	function automatic logic wr_hit(input logic strobe, input logic [3:0] addr,
		input logic [3:0] target);
		return strobe && addr == target;
	endfunction : wr_hit

	logic            wr_ovf;
	logic            wr_son;
	logic            wr_pct;
	logic            wr_spd;
	logic            wr_mask;
	logic            wr_stat;
	logic [EV_W-1:0] mask_d;
	assign wr_ovf  = wr_hit(reg_wr, reg_addr, ADDR_OVF_LEVEL);
	assign wr_son  = wr_hit(reg_wr, reg_addr, ADDR_SON_LEVEL);
	assign wr_pct  = wr_hit(reg_wr, reg_addr, ADDR_WARN_PCT);
	assign wr_spd  = wr_hit(reg_wr, reg_addr, ADDR_SPEED_LIM);
	assign wr_mask = wr_hit(reg_wr, reg_addr, ADDR_MASK);
	assign wr_stat = wr_hit(reg_wr, reg_addr, ADDR_STATUS);
	// Next mask, shared with irq so both move on the same edge
	assign mask_d  = wr_mask ? reg_wdata[EV_W-1:0] : mask_q;

	// Out-of-range writes are clipped rather than refused
	always_ff @(posedge clock) begin
		if (srst) begin
			overflow_alarm_level_q <= OVF_LEVEL_RST;
		end else if (wr_ovf) begin
			overflow_alarm_level_q <= clip_level(reg_wdata);
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			servo_on_alarm_level_q <= SON_LEVEL_RST;
		end else if (wr_son) begin
			servo_on_alarm_level_q <= clip_level(reg_wdata);
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			servo_on_warning_percent_q <= PCT_RST;
		end else if (wr_pct) begin
			if (reg_wdata > 32'(PCT_MAX))
				servo_on_warning_percent_q <= PCT_MAX;
			else if (reg_wdata < 32'(PCT_MIN))
				servo_on_warning_percent_q <= PCT_MIN;
			else
				servo_on_warning_percent_q <= reg_wdata[PCT_W-1:0];
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			servo_on_speed_limit_q <= SPEED_LIM_RST;
		end else if (wr_spd) begin
			if (reg_wdata > 32'(SPEED_MAX))
				servo_on_speed_limit_q <= SPEED_MAX;
			else
				servo_on_speed_limit_q <= reg_wdata[SPEED_W-1:0];
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			mask_q <= '0;
		end else begin
			mask_q <= mask_d;
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			reg_rdata <= '0;
		end else if (reg_rd) begin
			unique case (reg_addr)
				ADDR_OVF_LEVEL: reg_rdata <= 32'(overflow_alarm_level_q);
				ADDR_SON_LEVEL: reg_rdata <= 32'(servo_on_alarm_level_q);
				ADDR_WARN_PCT:  reg_rdata <= 32'(servo_on_warning_percent_q);
				ADDR_SPEED_LIM: reg_rdata <= 32'(servo_on_speed_limit_q);
				ADDR_STATUS:    reg_rdata <= 32'(status_q);
				ADDR_MASK:      reg_rdata <= 32'(mask_q);
				ADDR_ERROR:     reg_rdata <= err_count_q;
				default:        reg_rdata <= '0;
			endcase
		end else begin
			reg_rdata <= '0;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Error counter and level comparison

	error_level_if lv ();

	assign lv.err_mag   = err_count_q[ERR_W-1] ? ERR_W'(-err_count_q) : err_count_q;
	assign lv.ovf_level = overflow_alarm_level_q;
	assign lv.son_level = servo_on_alarm_level_q;
	assign lv.warn_pct  = servo_on_warning_percent_q;

	error_level_compare u_cmp (
		.lv (lv.cmp)
	);

	// Feedback keeps counting while power is off so the residual is real
	always_ff @(posedge clock) begin
		if (srst) begin
			err_count_q <= '0;
		end else if (!pos_control) begin
			err_count_q <= '0;
		end else begin
			err_count_q <= err_count_q + (ref_valid ? ref_delta : '0) - fb_delta;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Servo sequence

	logic son_rise;
	logic servo_on_q;
	logic ev_ovf;
	logic ev_son;
	logic ev_clamp;
	logic ev_warn;
	logic any_alarm;

	always_ff @(posedge clock) begin
		if (srst) begin
			servo_on_q <= 1'b0;
		end else begin
			servo_on_q <= servo_on;
		end
	end

	// The power-on check runs only from OFF; STOP waits for a clear
	assign son_rise  = servo_on && !servo_on_q && pos_control && state_q == ST_OFF;
	assign ev_son    = son_rise && lv.over_son;
	assign ev_warn   = son_rise && lv.over_warn;
	assign ev_clamp  = state_q == ST_CLAMP && ref_valid && lv.over_ovf;
	assign ev_ovf    = state_q == ST_RUN && lv.over_ovf;
	assign any_alarm = error_overflow_alarm || servo_on_overflow_alarm
		|| speed_clamp_overflow_alarm;

	always_ff @(posedge clock) begin
		if (srst) begin
			state_q <= ST_OFF;
		end else begin
			unique case (state_q)
				ST_OFF: begin
					if (son_rise) begin
						if (lv.over_son)
							state_q <= ST_STOP;
						else if (err_count_q != '0)
							state_q <= ST_CLAMP;
						else
							state_q <= ST_RUN;
					end
				end
				ST_CLAMP: begin
					if (!servo_on || !pos_control)
						state_q <= ST_OFF;
					else if (ev_clamp)
						state_q <= ST_STOP;
					else if (err_count_q == '0)
						state_q <= ST_RUN;
				end
				ST_RUN: begin
					if (ev_ovf)
						state_q <= ST_STOP;
					else if (!servo_on || !pos_control)
						state_q <= ST_OFF;
				end
				ST_STOP: begin
					// Held here whatever servo_on does
					if (alarm_clear)
						state_q <= ST_OFF;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////
	// Latched alarms and outputs

	always_ff @(posedge clock) begin
		if (srst) begin
			error_overflow_alarm       <= 1'b0;
			servo_on_overflow_alarm    <= 1'b0;
			speed_clamp_overflow_alarm <= 1'b0;
			servo_on_warning           <= 1'b0;
		end else begin
			// New events win over a clear in the same cycle
			error_overflow_alarm       <= ev_ovf || (error_overflow_alarm && !alarm_clear);
			servo_on_overflow_alarm    <= ev_son || (servo_on_overflow_alarm && !alarm_clear);
			speed_clamp_overflow_alarm <= ev_clamp || (speed_clamp_overflow_alarm && !alarm_clear);
			servo_on_warning           <= ev_warn || (servo_on_warning && !alarm_clear);
		end
	end

	// Status as it stands after this edge: irq rises with its status bit,
	// and a masked event never pulses it
	logic [EV_W-1:0] status_d;
	assign status_d = {ev_warn, ev_clamp, ev_son, ev_ovf}
		| (status_q & ~(wr_stat ? reg_wdata[EV_W-1:0] : '0));

	always_ff @(posedge clock) begin
		if (srst) begin
			status_q <= '0;
		end else begin
			status_q <= status_d;
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			irq <= 1'b0;
		end else begin
			irq <= |(status_d & mask_d);
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			motor_enable <= 1'b0;
			motor_stop   <= 1'b1;
			speed_clamp  <= 1'b0;
			speed_limit  <= SPEED_LIM_RST;
		end else begin
			// Stop as soon as the alarm event fires, on the same edge that moves the state to STOP
			motor_stop   <= ev_ovf || ev_son || ev_clamp || any_alarm
				|| (state_q == ST_STOP) || !servo_on;
			motor_enable <= (state_q == ST_CLAMP || state_q == ST_RUN)
				&& !(ev_ovf || ev_clamp) && !any_alarm;
			speed_clamp  <= state_q == ST_CLAMP;
			speed_limit  <= state_q == ST_CLAMP ? servo_on_speed_limit_q : SPEED_MAX;
		end
	end

endmodule : position_error_guard
`default_nettype wire

// File: rtl/position_error_guard_pkg.sv
package position_error_guard_pkg;

	localparam int unsigned LEVEL_W            = 30;
	localparam int unsigned ERR_W              = 32;
	localparam int unsigned POS_W              = 32;
	localparam int unsigned SPEED_W            = 14;
	localparam int unsigned PCT_W              = 7;

	localparam logic [LEVEL_W-1:0] LEVEL_MIN   = 30'h0000_0001;
	localparam logic [LEVEL_W-1:0] LEVEL_MAX   = 30'h3FFF_FFFF;
	localparam logic [LEVEL_W-1:0] OVF_LEVEL_RST  = 30'h0050_0000;
	localparam logic [LEVEL_W-1:0] SON_LEVEL_RST  = 30'h0050_0000;
	localparam logic [SPEED_W-1:0] SPEED_MAX      = 14'h2710;
	localparam logic [SPEED_W-1:0] SPEED_LIM_RST  = 14'h2710;
	localparam logic [PCT_W-1:0]   PCT_MIN        = 7'h0A;
	localparam logic [PCT_W-1:0]   PCT_MAX        = 7'h64;
	localparam logic [PCT_W-1:0]   PCT_RST        = 7'h64;

	localparam logic [3:0] ADDR_OVF_LEVEL  = 4'h0;
	localparam logic [3:0] ADDR_SON_LEVEL  = 4'h1;
	localparam logic [3:0] ADDR_WARN_PCT   = 4'h2;
	localparam logic [3:0] ADDR_SPEED_LIM  = 4'h3;
	localparam logic [3:0] ADDR_STATUS     = 4'h4;
	localparam logic [3:0] ADDR_MASK       = 4'h5;
	localparam logic [3:0] ADDR_ERROR      = 4'h6;

	localparam int unsigned EV_OVF   = 0;
	localparam int unsigned EV_SON   = 1;
	localparam int unsigned EV_CLAMP = 2;
	localparam int unsigned EV_WARN  = 3;
	localparam int unsigned EV_W     = 4;

	typedef enum logic [1:0] {
		ST_OFF,
		ST_CLAMP,
		ST_RUN,
		ST_STOP
	} guard_state_t;

endpackage : position_error_guard_pkg

// File: rtl/error_level_if.sv
`timescale 1ns/1ns
`default_nettype none
interface error_level_if;
	import position_error_guard_pkg::*;
	logic [ERR_W-1:0]   err_mag;      // Magnitude of error count
	logic [LEVEL_W-1:0] ovf_level;    // Main alarm level
	logic [LEVEL_W-1:0] son_level;    // Servo-on alarm level
	logic [PCT_W-1:0]   warn_pct;     // Warning percent
	logic               over_ovf;     // Error above main level
	logic               over_son;     // Error above servo-on level
	logic               over_warn;    // Error above warning level
	modport cmp (input err_mag, ovf_level, son_level, warn_pct,
		output over_ovf, over_son, over_warn);
	modport user (output err_mag, ovf_level, son_level, warn_pct,
		input over_ovf, over_son, over_warn);
endinterface : error_level_if
`default_nettype wire

// File: rtl/error_level_compare.sv
`timescale 1ns/1ns
`default_nettype none
module error_level_compare
	import position_error_guard_pkg::*;
(
	error_level_if.cmp lv    // Levels in, comparisons out
);
	// Wide enough for the largest error magnitude times one hundred
	localparam int unsigned PROD_W = ERR_W + PCT_W;

	logic [PROD_W-1:0] warn_scaled;
	logic [PROD_W-1:0] err_scaled;

	// Compare error*100 against level*pct so no divider is needed
	assign warn_scaled  = PROD_W'(lv.son_level) * PROD_W'(lv.warn_pct);
	assign err_scaled   = PROD_W'(lv.err_mag) * PROD_W'(PCT_MAX);
	assign lv.over_ovf  = lv.err_mag > ERR_W'(lv.ovf_level);
	assign lv.over_son  = lv.err_mag > ERR_W'(lv.son_level);
	assign lv.over_warn = err_scaled > warn_scaled;
endmodule : error_level_compare
`default_nettype wire

// File: tb/host_ref_model.sv
`timescale 1ns/1ns
`default_nettype none
module host_ref_model (
	input  wire logic        clock,     // Control clock
	input  wire logic        srst,      // Sync reset
	input  wire logic        go,        // Issue references
	input  wire logic [31:0] step,      // Increment to issue
	output logic             ref_valid, // Reference present
	output logic      [31:0] ref_delta  // Reference increment
);
	// Idle data toggles so a stale increment never looks like a fresh one
	always_ff @(posedge clock) begin
		if (srst) begin
			ref_valid <= 1'b0;
			ref_delta <= '0;
		end else if (go) begin
			ref_valid <= 1'b1;
			ref_delta <= step;
		end else begin
			ref_valid <= 1'b0;
			ref_delta <= ~ref_delta;
		end
	end
endmodule : host_ref_model
`default_nettype wire

// File: tb/position_error_guard_checker.sv
`timescale 1ns/1ns
`default_nettype none
module position_error_guard_checker
	import position_error_guard_pkg::*;
(
	input wire logic               clock,                      // Clock
	input wire logic               srst,                       // Reset
	input wire logic               servo_on,                   // Power request
	input wire logic               ref_valid,                  // Reference
	input wire logic               alarm_clear,                // Clear
	input wire logic               reg_rd,                     // Read strobe
	input wire logic [31:0]        reg_rdata,                  // Read data
	input wire logic               motor_stop,                 // Stop
	input wire logic               speed_clamp,                // Clamp
	input wire logic [SPEED_W-1:0] speed_limit,                // Ceiling
	input wire logic               error_overflow_alarm,       // Main alarm
	input wire logic               servo_on_overflow_alarm,    // Power-on alarm
	input wire logic               speed_clamp_overflow_alarm, // Clamp alarm
	input wire logic               servo_on_warning            // Warning
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (srst);
	rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
		else $error("read data outside read slot");
	ovf_stop_a: assert property (error_overflow_alarm |-> motor_stop)
		else $error("main alarm without stop");
	son_stop_a: assert property (servo_on_overflow_alarm |-> motor_stop)
		else $error("power-on alarm without stop");
	ovf_latch_a: assert property (error_overflow_alarm && !alarm_clear |=> error_overflow_alarm)
		else $error("main alarm dropped");
	warn_latch_a: assert property (servo_on_warning && !alarm_clear |=> servo_on_warning)
		else $error("warning dropped");
	clamp_cause_a: assert property ($rose(speed_clamp_overflow_alarm) |-> $past(ref_valid))
		else $error("clamp alarm without reference");
	son_cause_a: assert property ($rose(servo_on_overflow_alarm) |-> $past(servo_on) && !$past(servo_on, 2))
		else $error("power-on alarm off its edge");
	limit_free_a: assert property (!speed_clamp |-> speed_limit == SPEED_LIM_RST)
		else $error("speed ceiling without clamp");
	cover property ($rose(error_overflow_alarm));
	cover property ($rose(speed_clamp_overflow_alarm));
	cover property ($fell(speed_clamp));
endmodule : position_error_guard_checker
bind position_error_guard position_error_guard_checker i_position_error_guard_checker (
	.clock, .srst, .servo_on, .ref_valid, .alarm_clear, .reg_rd, .reg_rdata, .motor_stop,
	.speed_clamp, .speed_limit, .error_overflow_alarm, .servo_on_overflow_alarm,
	.speed_clamp_overflow_alarm, .servo_on_warning);
`default_nettype wire

// File: tb/testbench.sv
`timescale 1ns/1ns
`default_nettype none
module testbench
	import position_error_guard_pkg::*;
;
	logic               clock = 1'b0, srst = 1'b1, pos_control = 1'b1, servo_on = 1'b0;
	logic               alarm_clear = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, go = 1'b0;
	logic [31:0]        fb_delta = '0, step = '0, reg_wdata = '0, reg_rdata, ref_delta;
	logic [3:0]         reg_addr = '0;
	logic               ref_valid, motor_enable, motor_stop, speed_clamp, irq;
	logic               error_overflow_alarm, servo_on_overflow_alarm;
	logic               speed_clamp_overflow_alarm, servo_on_warning;
	logic [SPEED_W-1:0] speed_limit;
	int                 n_fail = 0, samples_checked = 0, m_err = 0;
	logic [31:0]        dflt [8] = '{32'h00500000, 32'h00500000, 32'h64, 32'h2710,
		32'h0, 32'h0, 32'h0, 32'h0};
	logic [31:0]        cw [8] = '{32'h0, 32'hFFFFFFFF, 32'h5, 32'h4E20, 32'h64, 32'h32, 32'h32, 32'h7B};
	logic [31:0]        ce [8] = '{32'h1, 32'h3FFFFFFF, 32'hA, 32'h2710, 32'h64, 32'h32, 32'h32, 32'h7B};

	always #25 clock = ~clock;
	// Reference model of the error counter
	always @(posedge clock) begin
		if (srst || !pos_control)
			m_err <= 0;
		else
			m_err <= m_err + (ref_valid ? int'(ref_delta) : 0) - int'(fb_delta);
	end

	host_ref_model i_host_ref_model (.clock, .srst, .go, .step, .ref_valid, .ref_delta);
	position_error_guard i_position_error_guard (.clock, .srst, .pos_control, .servo_on,
		.ref_delta, .ref_valid, .fb_delta, .alarm_clear, .reg_addr, .reg_wdata, .reg_wr,
		.reg_rd, .reg_rdata, .motor_enable, .motor_stop, .speed_clamp, .speed_limit,
		.error_overflow_alarm, .servo_on_overflow_alarm, .speed_clamp_overflow_alarm,
		.servo_on_warning, .irq);
	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic ticks(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask : ticks
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clock);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clock);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [3:0] a, input logic [31:0] exp);
		@(posedge clock);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clock);
		reg_rd <= 1'b0;
		#1 chk(reg_rdata, exp);
	endtask : rd
	// Feedback moves the counter to an exact value in one cycle
	task automatic set_err(input int t);
		@(posedge clock);
		fb_delta <= m_err - t;
		@(posedge clock);
		fb_delta <= '0;
	endtask : set_err
	task automatic son_up();
		@(posedge clock);
		servo_on <= 1'b1;
		ticks(3);
	endtask : son_up
	task automatic off_clr();
		@(posedge clock);
		servo_on <= 1'b0;
		alarm_clear <= 1'b1;
		@(posedge clock);
		alarm_clear <= 1'b0;
		ticks(2);
	endtask : off_clr
	task automatic push(input int n, input int s);
		@(posedge clock);
		go <= 1'b1;
		step <= s;
		repeat (n) @(posedge clock);
		go <= 1'b0;
		ticks(3);
	endtask : push
	task automatic final_report();
		$display("checked %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : final_report
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (5000) @(posedge clock);
		n_fail++;
		final_report();
	end
	initial begin
		void'($urandom(32'h3175764F));
		repeat (4) @(posedge clock);
		srst <= 1'b0;
		for (int a = 0; a < 8; a++)
			rd(4'(a), dflt[a]);
		for (int i = 0; i < 8; i++) begin
			wr(4'(i % 4), cw[i]);
			rd(4'(i % 4), ce[i]);
		end
		$display("settings done");
		for (int i = 0; i < 20; i++) begin
			@(posedge clock);
			go <= 1'b1;
			step <= $urandom_range(0, 200) - 100;
			fb_delta <= $urandom_range(0, 200) - 100;
		end
		@(posedge clock);
		go <= 1'b0;
		fb_delta <= '0;
		ticks(3);
		rd(ADDR_ERROR, m_err);
		@(posedge clock);
		pos_control <= 1'b0;
		@(posedge clock);
		pos_control <= 1'b1;
		rd(ADDR_ERROR, 32'h0);
		$display("accumulate done");
		son_up();
		chk(motor_enable, 32'h1);
		set_err(100);
		ticks(3);
		chk(error_overflow_alarm, 32'h0);
		set_err(-101);
		ticks(2);
		chk(error_overflow_alarm, 32'h1);
		chk(motor_stop, 32'h1);
		rd(ADDR_STATUS, 32'h1);
		chk(irq, 32'h0);
		wr(ADDR_MASK, 32'h1);
		ticks(2);
		chk(irq, 32'h1);
		wr(ADDR_STATUS, 32'h1);
		ticks(2);
		chk(irq, 32'h0);
		chk(error_overflow_alarm, 32'h1);
		off_clr();
		chk(error_overflow_alarm, 32'h0);
		$display("run overflow done");
		set_err(51);
		son_up();
		chk(servo_on_overflow_alarm, 32'h1);
		chk(servo_on_warning, 32'h1);
		chk(motor_enable, 32'h0);
		rd(ADDR_STATUS, 32'hA);
		chk(irq, 32'h0);
		wr(ADDR_STATUS, 32'hF);
		off_clr();
		chk(servo_on_overflow_alarm, 32'h0);
		$display("power-on overflow done");
		set_err(50);
		son_up();
		chk(servo_on_overflow_alarm, 32'h0);
		chk(servo_on_warning, 32'h1);
		chk(speed_clamp, 32'h1);
		chk(speed_limit, 32'h7B);
		push(3, 40);
		chk(speed_clamp_overflow_alarm, 32'h1);
		chk(motor_stop, 32'h1);
		rd(ADDR_STATUS, 32'hC);
		wr(ADDR_STATUS, 32'hF);
		off_clr();
		$display("clamp overflow done");
		set_err(25);
		son_up();
		chk(servo_on_warning, 32'h0);
		chk(speed_clamp, 32'h1);
		set_err(0);
		ticks(3);
		chk(speed_clamp, 32'h0);
		chk(speed_limit, 32'h2710);
		chk(motor_enable, 32'h1);
		$display("clamp release done");
		@(posedge clock);
		pos_control <= 1'b0;
		ticks(3);
		chk(motor_enable, 32'h0);
		rd(ADDR_ERROR, 32'h0);
		$display("mode exit done");
		final_report();
	end
endmodule : testbench
`default_nettype wire
